/* File: ppdu_pkg.sv */
// Package for the period/duty PWM unit: field layouts, reset values, modes.
// Assumes a single 200 MHz clock domain and plain control ports, no register bus.
package ppdu_pkg;

    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned CLK_PERIOD_PS    = 1_000_000 / CLK_MHZ;

    // One oscillator period is one system clock; four make an instruction cycle
    localparam logic [1:0]  Q_PHASES_M1      = 2'h3;

    localparam logic [7:0]  PERIOD_LIMIT_RST = 8'hFF;
    localparam logic [7:0]  COUNTER_RST      = 8'h00;
    localparam logic [5:0]  CPC_RST          = 6'h00;
    localparam logic [6:0]  PTC_RST          = 7'h00;
    localparam logic [9:0]  DUTY_ZERO        = 10'h000;

    // Capture/PWM control field positions
    localparam int unsigned CPC_DUTY_LO_HI   = 5;
    localparam int unsigned CPC_DUTY_LO_LO   = 4;
    localparam int unsigned CPC_MODE_HI      = 3;
    localparam int unsigned CPC_MODE_LO      = 0;
    localparam logic [1:0]  CPC_PWM_SEL      = 2'h3;

    // Period timer control field positions
    localparam int unsigned PTC_POST_HI      = 6;
    localparam int unsigned PTC_POST_LO      = 3;
    localparam int unsigned PTC_ON_BIT       = 2;
    localparam int unsigned PTC_PRE_HI       = 1;
    localparam int unsigned PTC_PRE_LO       = 0;

    // Prescaler ratios 1, 4, 16 in instruction cycles
    localparam logic [3:0]  PRE_DIV1_M1      = 4'h0;
    localparam logic [3:0]  PRE_DIV4_M1      = 4'h3;
    localparam logic [3:0]  PRE_DIV16_M1     = 4'hF;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] data;
    } ppdu_wr8_t;

    typedef struct packed {
        logic       wr_en;
        logic [6:0] data;
    } ppdu_wr7_t;

    typedef struct packed {
        logic       wr_en;
        logic [5:0] data;
    } ppdu_wr6_t;

    typedef enum logic [2:0] {
        PPDU_OFF  = 3'b001,
        PPDU_HIGH = 3'b010,
        PPDU_LOW  = 3'b100
    } ppdu_out_state_t;

endpackage

/* File: ppdu_prescaler.sv */
// Period timer prescaler: instruction-cycle phase and divided increment pulse.
// Assumes same-clock enables from the main unit.
`timescale 1ns/1ps
`default_nettype none
module ppdu_prescaler (
    input  wire logic       clk,      // System clock, one oscillator period
    input  wire logic       rst,      // Synchronous reset, active high
    input  wire logic       run,      // Timer on
    input  wire logic [1:0] pre_sel,  // Prescale select
    output logic            inc,      // Timer increment pulse
    output logic [3:0]      pre_cnt,  // Prescale count only, q phase not included
    output logic [1:0]      sub_bits  // Two low compare bits
);
    logic [1:0] q_r;
    logic [3:0] p_r;
    wire  [3:0] p_max;
    wire        q_end;
    wire        p_end;

    function automatic logic [3:0] div_m1(input logic [1:0] sel);
        case (sel)
            2'h0:    div_m1 = ppdu_pkg::PRE_DIV1_M1;
            2'h1:    div_m1 = ppdu_pkg::PRE_DIV4_M1;
            default: div_m1 = ppdu_pkg::PRE_DIV16_M1;
        endcase
    endfunction

    assign p_max = div_m1(pre_sel);
    assign q_end = (q_r == ppdu_pkg::Q_PHASES_M1);
    assign p_end = (p_r >= p_max);
    assign inc   = run && q_end && p_end; // R19
    assign pre_cnt = p_r;
    // Sub-period bits: q phase at 1:1, low two prescale bits at 1:4, top two at 1:16,
    // so every sub-step is a quarter of one counter step at any ratio
    assign sub_bits = (pre_sel == 2'h0) ? q_r :
                      (pre_sel == 2'h1) ? p_r[1:0] : p_r[3:2]; // R11

    always_ff @(posedge clk) begin
        if (rst || !run) begin
            q_r <= 2'h0;
            p_r <= 4'h0;
        end else begin
            q_r <= q_r + 2'h1;
            if (q_end) begin
                p_r <= p_end ? 4'h0 : p_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: ppdu_top.sv */
// Period/duty PWM unit: period timer, double-buffered 10-bit duty, output pin.
// Assumes control writes arrive as same-clock strobes; no register bus.
//
// Contract
// R01: Period is (limit+1)*4*prescale oscillator periods
// R02: Counter clears on increment after limit match
// R03: Output set at period start unless duty zero
// R04: Staged duty copied to active at match
// R05: Postscaler affects only match event rate
// R06: Duty is staging byte plus control bits 5:4
// R07: High time is duty*osc period*prescale
// R08: Duty writes anytime, effective next period
// R09: Active duty read-only in PWM mode
// R10: Double buffer with 2-bit low latch
// R11: Clear output when duty equals extended counter
// R12: Duty beyond period keeps output high
// R13: Period limit resets and wakes to ones
// R14: Counter clears on reset, kept over wake
// R15: Capture/PWM control clears on reset
// R16: Timer control clears; top bit reads zero
// R17: Clearing control forces output latch low
// R18: Software must enable pin direction externally
// R19: Counter advances per instruction cycle over prescale
`timescale 1ns/1ps
`default_nettype none
module ppdu_top (
    input  wire logic               clk,                  // 200 MHz system clock
    input  wire logic               rst,                  // Synchronous reset, any reset type
    input  wire logic               wake,                 // Wake-up from sleep pulse
    input  wire ppdu_pkg::ppdu_wr8_t period_limit_wr,     // Period limit write
    input  wire ppdu_pkg::ppdu_wr8_t duty_staging_wr,     // Duty staging write
    input  wire ppdu_pkg::ppdu_wr8_t duty_active_wr,      // Active duty write
    input  wire ppdu_pkg::ppdu_wr6_t capture_pwm_ctrl_wr, // Capture/PWM control write
    input  wire ppdu_pkg::ppdu_wr7_t period_timer_ctrl_wr,// Period timer control write
    output logic [7:0]              period_limit,         // Period limit readback
    output logic [7:0]              period_counter,       // Period counter readback
    output logic [7:0]              duty_staging,         // Duty staging readback
    output logic [7:0]              duty_active,          // Active duty readback
    output logic [7:0]              capture_pwm_control,  // Control readback, top two bits zero
    output logic [7:0]              period_timer_control, // Timer control readback, bit 7 zero
    output logic                    match_event,          // Postscaled timer match pulse
    output logic                    pwm_output_pin        // PWM output latch
);
    logic [7:0]  limit_r;
    logic [7:0]  cnt_r;
    logic [7:0]  stage_r;
    logic [7:0]  active_r;
    logic [1:0]  active_lo_r;
    logic [5:0]  cpc_r;
    logic [6:0]  ptc_r;
    logic [3:0]  post_r;
    logic        match_r;
    logic        pin_r;
    ppdu_pkg::ppdu_out_state_t st_r;
    ppdu_pkg::ppdu_out_state_t st_nxt;

    wire         inc;
    wire [1:0]   sub_bits;
    wire         run;
    wire         pwm_mode;
    wire         at_limit;
    wire         period_start;
    wire [9:0]   staged_duty;
    wire [9:0]   live_duty;
    wire [9:0]   ext_count;
    wire         duty_hit;
    wire         post_end;

    assign run      = ptc_r[ppdu_pkg::PTC_ON_BIT];
    assign pwm_mode = (cpc_r[ppdu_pkg::CPC_MODE_HI -: 2] == ppdu_pkg::CPC_PWM_SEL);
    assign at_limit = (cnt_r == limit_r);
    assign period_start = inc && at_limit;                                        // R02
    assign staged_duty  = {stage_r, cpc_r[ppdu_pkg::CPC_DUTY_LO_HI:ppdu_pkg::CPC_DUTY_LO_LO]}; // R06
    assign live_duty    = {active_r, active_lo_r};                                // R10
    assign ext_count    = {cnt_r, sub_bits};                                      // R11
    // Duty longer than the period never matches, so the pin stays high
    assign duty_hit     = (live_duty == ext_count);                               // R12
    assign post_end     = (post_r == ptc_r[ppdu_pkg::PTC_POST_HI:ppdu_pkg::PTC_POST_LO]);

    ppdu_prescaler u_pre (
        .clk      (clk),
        .rst      (rst),
        .run      (run),
        .pre_sel  (ptc_r[ppdu_pkg::PTC_PRE_HI:ppdu_pkg::PTC_PRE_LO]),
        .inc      (inc),
        .pre_cnt  (),
        .sub_bits (sub_bits)
    );

    // Configuration registers; wake leaves them alone except the limit
    always_ff @(posedge clk) begin
        if (rst || wake) begin
            limit_r <= ppdu_pkg::PERIOD_LIMIT_RST;                                // R13
        end else if (period_limit_wr.wr_en) begin
            limit_r <= period_limit_wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cpc_r <= ppdu_pkg::CPC_RST;                                           // R15
            ptc_r <= ppdu_pkg::PTC_RST;                                           // R16
        end else begin
            if (capture_pwm_ctrl_wr.wr_en) begin
                cpc_r <= capture_pwm_ctrl_wr.data;                                // R08
            end
            if (period_timer_ctrl_wr.wr_en) begin
                ptc_r <= period_timer_ctrl_wr.data;
            end
        end
    end

    // Staging is never reset; writes land immediately, pulse untouched
    always_ff @(posedge clk) begin
        if (duty_staging_wr.wr_en) begin
            stage_r <= duty_staging_wr.data;                                      // R08
        end
    end

    // Period counter: wrap at limit match (R01 period length)
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= ppdu_pkg::COUNTER_RST;                                       // R14
        end else if (period_start) begin
            cnt_r <= ppdu_pkg::COUNTER_RST;                                       // R01 R02
        end else if (inc) begin
            cnt_r <= cnt_r + 8'h01;                                               // R19
        end
    end

    // Active duty: loads only at the period boundary in PWM mode
    always_ff @(posedge clk) begin
        if (rst) begin
            active_r    <= 8'h00;
            active_lo_r <= 2'h0;
        end else if (pwm_mode) begin
            if (period_start) begin
                active_r    <= staged_duty[9:2];                                  // R04
                active_lo_r <= staged_duty[1:0];                                  // R10
            end
        end else if (duty_active_wr.wr_en) begin
            active_r <= duty_active_wr.data;                                      // R09
        end
    end

    // Postscaler only paces the match event, never the PWM period
    always_ff @(posedge clk) begin
        if (rst) begin
            post_r  <= 4'h0;
            match_r <= 1'b0;
        end else begin
            match_r <= period_start && post_end;                                  // R05
            if (period_start) begin
                post_r <= post_end ? 4'h0 : post_r + 4'h1;
            end
        end
    end

    // Output latch state machine
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ppdu_pkg::PPDU_OFF: begin
                if (pwm_mode && period_start) begin
                    st_nxt = (staged_duty == ppdu_pkg::DUTY_ZERO) ? ppdu_pkg::PPDU_LOW
                                                                  : ppdu_pkg::PPDU_HIGH; // R03
                end
            end
            ppdu_pkg::PPDU_HIGH: begin
                if (!pwm_mode) begin
                    st_nxt = ppdu_pkg::PPDU_OFF;                                  // R17
                end else if (period_start) begin
                    st_nxt = (staged_duty == ppdu_pkg::DUTY_ZERO) ? ppdu_pkg::PPDU_LOW
                                                                  : ppdu_pkg::PPDU_HIGH; // R03
                end else if (run && duty_hit) begin
                    st_nxt = ppdu_pkg::PPDU_LOW;                                  // R07 R11
                end
            end
            ppdu_pkg::PPDU_LOW: begin
                if (!pwm_mode) begin
                    st_nxt = ppdu_pkg::PPDU_OFF;                                  // R17
                end else if (period_start && staged_duty != ppdu_pkg::DUTY_ZERO) begin
                    st_nxt = ppdu_pkg::PPDU_HIGH;                                 // R03
                end
            end
            default: st_nxt = ppdu_pkg::PPDU_OFF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r  <= ppdu_pkg::PPDU_OFF;
            pin_r <= 1'b0;                                                        // R17
        end else begin
            st_r  <= st_nxt;
            // Rise one clock after the wrap: the compare sees count d only after
            // d clocks, so following st_nxt would give duty plus one clocks high
            pin_r <= (st_r == ppdu_pkg::PPDU_HIGH) && (st_nxt == ppdu_pkg::PPDU_HIGH); // R07
        end
    end

    // Registered readbacks
    always_ff @(posedge clk) begin
        if (rst) begin
            period_limit         <= ppdu_pkg::PERIOD_LIMIT_RST;
            period_counter       <= ppdu_pkg::COUNTER_RST;
            duty_staging         <= 8'h00;
            duty_active          <= 8'h00;
            capture_pwm_control  <= 8'h00;
            period_timer_control <= 8'h00;
            match_event          <= 1'b0;
            pwm_output_pin       <= 1'b0;
        end else begin
            period_limit         <= limit_r;
            period_counter       <= cnt_r;
            duty_staging         <= stage_r;
            duty_active          <= active_r;
            capture_pwm_control  <= {2'h0, cpc_r};
            period_timer_control <= {1'b0, ptc_r};                                // R16
            match_event          <= match_r;
            pwm_output_pin       <= pin_r;
        end
    end
endmodule
`default_nettype wire

/* File: ppdu_top_chk.sv */
// Assertion checker for the period/duty PWM unit, bound to ppdu_top.
// Sees only the top ports; one clock domain, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ppdu_top_chk (
    input wire logic                clk,                  // Clock
    input wire logic                rst,                  // Reset
    input wire logic                wake,                 // Wake pulse
    input wire ppdu_pkg::ppdu_wr8_t period_limit_wr,      // Limit write
    input wire ppdu_pkg::ppdu_wr8_t duty_staging_wr,      // Staging write
    input wire ppdu_pkg::ppdu_wr8_t duty_active_wr,       // Active write
    input wire ppdu_pkg::ppdu_wr6_t capture_pwm_ctrl_wr,  // Control write
    input wire ppdu_pkg::ppdu_wr7_t period_timer_ctrl_wr, // Timer write
    input wire logic [7:0]          period_limit,         // Limit
    input wire logic [7:0]          period_counter,       // Counter
    input wire logic [7:0]          duty_staging,         // Staging
    input wire logic [7:0]          duty_active,          // Active duty
    input wire logic [7:0]          capture_pwm_control,  // Control
    input wire logic [7:0]          period_timer_control, // Timer control
    input wire logic                match_event,          // Match pulse
    input wire logic                pwm_output_pin        // Pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Two reset edges so the readback stage has flushed
    chk_limit_reset: assert property (disable iff (1'b0) rst[*2] |=> period_limit == 8'hFF)
        else $error("limit not ones after reset");
    chk_count_reset: assert property (disable iff (1'b0) rst[*2] |=> period_counter == 8'h00)
        else $error("counter not cleared by reset");
    chk_ctrl_reset: assert property (disable iff (1'b0)
        rst[*2] |=> capture_pwm_control == 8'h00 && period_timer_control == 8'h00)
        else $error("control not cleared by reset");
    chk_unimpl_zero: assert property (capture_pwm_control[7:6] == 2'b00 && !period_timer_control[7])
        else $error("unimplemented bits read nonzero");
    chk_wake_limit: assert property (wake && !period_limit_wr.wr_en |-> ##2 period_limit == 8'hFF)
        else $error("limit not reloaded on wake");
    chk_count_step: assert property ($changed(period_counter) && period_counter != 8'h00 |->
        period_counter == $past(period_counter) + 8'h01)
        else $error("counter skipped a value");
    chk_count_wrap: assert property ($changed(period_counter) && period_counter == 8'h00 |->
        $past(period_counter) == $past(period_limit))
        else $error("counter cleared away from limit");
    chk_rise_start: assert property ($rose(pwm_output_pin) |-> period_counter == 8'h00)
        else $error("pin rose inside a period");
    chk_off_low: assert property ((capture_pwm_control[3:2] != 2'b11)[*3] |-> !pwm_output_pin)
        else $error("pin high outside pwm mode");
    chk_duty_boundary: assert property ($changed(duty_active) && $past(capture_pwm_control[3:2]) == 2'b11
        |-> period_counter == 8'h00)
        else $error("active duty changed mid period");

    cover property ($rose(pwm_output_pin));
    cover property ($changed(duty_active));
    cover property (wake);
endmodule
bind ppdu_top ppdu_top_chk ppdu_top_chk_i (.clk(clk), .rst(rst), .wake(wake), .period_limit_wr(period_limit_wr),
    .duty_staging_wr(duty_staging_wr), .duty_active_wr(duty_active_wr), .capture_pwm_ctrl_wr(capture_pwm_ctrl_wr),
    .period_timer_ctrl_wr(period_timer_ctrl_wr), .period_limit(period_limit), .period_counter(period_counter),
    .duty_staging(duty_staging), .duty_active(duty_active), .capture_pwm_control(capture_pwm_control),
    .period_timer_control(period_timer_control), .match_event(match_event), .pwm_output_pin(pwm_output_pin));
`default_nettype wire

/* File: ppdu_load_model.sv */
// Load on the PWM pin: measures high time and period in clocks.
// Pin is taken as already enabled as an output.
`timescale 1ns/1ps
`default_nettype none
module ppdu_load_model (
    input  wire logic       clk,     // Clock
    input  wire logic       rst,     // Reset
    input  wire logic       pin,     // PWM level
    output logic      [7:0] hi_len,  // Last high time
    output logic      [7:0] per_len  // Last rise to rise
);
    logic       pin_r;
    logic [7:0] run_r;
    always_ff @(posedge clk) begin
        pin_r <= pin;
        run_r <= (pin && !pin_r) ? 8'h01 : run_r + 8'h01;
        if (pin && !pin_r) begin
            per_len <= run_r;
        end
        if (!pin && pin_r) begin
            hi_len <= run_r;
        end
        if (rst) begin
            pin_r <= 1'b0;
            hi_len <= 8'h00;
            per_len <= 8'h00;
        end
    end
endmodule
`default_nettype wire

/* File: ppdu_top_bench.sv */
// Bench for the period/duty PWM unit with a pin load model.
// Prescale 1 gives four clocks per counter step.
`timescale 1ns/1ps
`default_nettype none
module ppdu_top_bench;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                wake = 1'b0;
    ppdu_pkg::ppdu_wr8_t lim_w = '0;
    ppdu_pkg::ppdu_wr8_t stg_w = '0;
    ppdu_pkg::ppdu_wr8_t act_w = '0;
    ppdu_pkg::ppdu_wr6_t cpc_w = '0;
    ppdu_pkg::ppdu_wr7_t ptc_w = '0;
    logic [7:0]          lim, cnt, stg, act, cpc, ptc, hi_len, per_len;
    logic                ev, pin;
    int                  bad_count = 0;
    int                  num_checks = 0;

    always #2.5 clk = ~clk;

    ppdu_top ppdu_top_i (.clk(clk), .rst(rst), .wake(wake), .period_limit_wr(lim_w), .duty_staging_wr(stg_w),
        .duty_active_wr(act_w), .capture_pwm_ctrl_wr(cpc_w), .period_timer_ctrl_wr(ptc_w),
        .period_limit(lim), .period_counter(cnt), .duty_staging(stg), .duty_active(act),
        .capture_pwm_control(cpc), .period_timer_control(ptc), .match_event(ev), .pwm_output_pin(pin));
    ppdu_load_model ppdu_load_model_i (.clk(clk), .rst(rst), .pin(pin), .hi_len(hi_len), .per_len(per_len));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Strobe for one cycle; a later call waits an edge, so no double drive
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge clk);
        case (k)
            0: lim_w <= {1'b1, d};
            1: stg_w <= {1'b1, d};
            2: act_w <= {1'b1, d};
            3: cpc_w <= {1'b1, d[5:0]};
            default: ptc_w <= {1'b1, d[6:0]};
        endcase
        @(posedge clk);
        lim_w.wr_en <= 1'b0;
        stg_w.wr_en <= 1'b0;
        act_w.wr_en <= 1'b0;
        cpc_w.wr_en <= 1'b0;
        ptc_w.wr_en <= 1'b0;
    endtask

    task automatic wait_pin(input logic v);
        for (int i = 0; i < 400 && pin !== v; i++) begin
            @(posedge clk);
        end
        chk(8'(pin), 8'(v));
    endtask

    task automatic t_reset();
        chk(lim, 8'hFF);
        chk(cnt, 8'h00);
        chk(cpc, 8'h00);
        chk(ptc, 8'h00);
        chk(8'(pin), 8'h00);
        wr(0, 8'h05);
        tick(2);
        chk(lim, 8'h05);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        tick(3);
        chk(lim, 8'hFF);
        chk(cnt, 8'h00);
    endtask

    // Limit 4, duty 14 quarter steps, prescale 1
    task automatic t_pwm();
        int n = 0;
        wr(0, 8'h04);
        wr(1, 8'h03);
        wr(3, 8'h2C);
        wr(4, 8'h0C);
        tick(70);
        chk(per_len, 8'd20);
        chk(hi_len, 8'd14);
        chk(act, 8'h03);
        chk(stg, 8'h03);
        // Postscale 2 halves only the match event rate
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            if (ev === 1'b1) begin
                n++;
            end
        end
        chk(8'(n), 8'h02);
    endtask

    task automatic t_change();
        wait_pin(1'b0);
        wait_pin(1'b1);
        wr(1, 8'h01);
        wr(3, 8'h0C);
        wait_pin(1'b0);
        tick(2);
        chk(hi_len, 8'd14);
        tick(45);
        chk(hi_len, 8'd4);
        chk(act, 8'h01);
        wr(2, 8'hAA);
        tick(3);
        chk(act, 8'h01);
    endtask

    // Postscale 16 must not stretch the period
    task automatic t_pre4();
        wr(4, 8'h7D);
        tick(260);
        chk(per_len, 8'd80);
        chk(hi_len, 8'd16);
        // Prescale 16, duty 14: quarter steps must come from the top prescale bits
        wr(1, 8'h03);
        wr(3, 8'h2C);
        wr(4, 8'h06);
        tick(700);
        chk(hi_len, 8'hE0);
        wr(4, 8'h04);
    endtask

    task automatic t_edges();
        wr(1, 8'hFF);
        wr(3, 8'h3C);
        tick(60);
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            chk(8'(pin), 8'h01);
        end
        wr(1, 8'h00);
        wr(3, 8'h0C);
        tick(60);
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            chk(8'(pin), 8'h00);
        end
        wr(1, 8'h03);
        wr(3, 8'h2C);
        tick(50);
        wait_pin(1'b1);
        wr(3, 8'h00);
        tick(4);
        chk(8'(pin), 8'h00);
        chk(cpc, 8'h00);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        tick(5);
        rst <= 1'b0;
        tick(2);
        t_reset();
        t_pwm();
        t_change();
        t_pre4();
        t_edges();
        conclude();
    end

    // Whole run is about 1500 clocks
    initial begin
        #20000;
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
